/* core/nand_host_ctrl.sv */
// Purpose: axi4-lite driven host controller for a nand flash device
// Assumes: one operation at a time, software waits for busy to clear
// Notes: page data is buffered here before a program
`timescale 1ns/100ps
module nand_host_ctrl #(
	parameter int IO_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   ce_n,
	output logic                   cle,
	output logic                   ale,
	output logic                   we_n,
	output logic                   read_strobe_n,
	output logic                   wp_n,
	output logic [IO_W-1:0]        io_out,
	output logic [IO_W-1:0]        io_oe,
	input  wire logic [IO_W-1:0]   io_in,
	input  wire logic              rb_in
);
	import nand_host_pkg::*;
	if (IO_W != 8 && IO_W != 16)
	begin : g_bad_width
		$error("IO_W must be 8 or 16");
	end

	typedef enum logic [10:0]
	{
		S_IDLE = 11'h001, S_PWR = 11'h002, S_PTR = 11'h004, S_CMD = 11'h008,
		S_ADR = 11'h010, S_DIN = 11'h020, S_CFM = 11'h040, S_BUSY = 11'h080,
		S_STC = 11'h100, S_RD = 11'h200, S_DONE = 11'h400
	} state_t;

	state_t      state_reg;
	op_t         op_reg;
	logic        spare_reg, phase_reg, issued_reg, refused_reg;
	logic [7:0]  cmd_reg, status_reg, maker_reg, device_reg;
	logic [24:0] addr_reg, dest_reg;
	logic [1:0]  acnt_reg;
	logic [9:0]  dcnt_reg, count_reg;
	logic [10:0] pwr_cnt_reg;
	logic [3:0]  wcnt_reg;
	logic        rcnt_reg;
	logic [15:0] last_page_reg, copied_page_reg;
	logic        copied_vld_reg;
	logic [1:0]  main_cnt_reg, spare_cnt_reg;
	logic [7:0]  waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic [7:0]  buf_mem [0:PAGE_BYTES-1];
	logic        wr_en, start, refuse, same_page, clr_refused;
	logic [1:0]  nadr;
	nand_cycle_if cyc ();

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	function automatic logic [7:0] addr_byte(input logic [24:0] a, input logic [1:0] idx,
		input op_t op);
		if (op == OP_READ_ID)
			return ID_ADDR;
		if (op == OP_ERASE)
			return (idx == 2'h0) ? a[16:9] : a[24:17];
		case (idx)
			2'h0: return a[7:0];
			2'h1: return a[16:9];
			default: return a[24:17];
		endcase
	endfunction : addr_byte

	////////////////////////////////////////////////////////////////
	// axi4-lite slave
	assign wr_en = !awready && !wready && !bvalid;
	assign start = wr_en && waddr_reg == OFS_CTRL && wstrb_reg[0];
	assign clr_refused = wr_en && waddr_reg == OFS_STAT && wstrb_reg[0]
		&& wdata_reg[STAT_REFUSED_BIT];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awready <= 1'b0;
				waddr_reg <= awaddr;
			end
			if (wvalid && wready)
			begin
				wready <= 1'b0;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end
			if (wr_en)
			begin
				bvalid <= 1'b1;
				awready <= 1'b1;
				wready <= 1'b1;
				bresp <= (waddr_reg > OFS_IDENT || waddr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'h0;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= 2'h0;
			case (araddr)
				OFS_CTRL: rdata <= {28'h0, spare_reg, op_reg};
				OFS_ADDR: rdata <= {7'h0, addr_reg};
				OFS_DEST: rdata <= {7'h0, dest_reg};
				OFS_DATA: rdata <= 32'h0;
				OFS_STAT: rdata <= {6'h0, count_reg, status_reg, 5'h0, refused_reg,
					status_reg[FS_FAIL_BIT], state_reg != S_IDLE};
				OFS_IDENT: rdata <= {16'h0, device_reg, maker_reg};
				default:
				begin
					rdata <= 32'h0;
					rresp <= 2'h2;
				end
			endcase
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// software registers and page buffer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			addr_reg <= 25'h0;
			dest_reg <= 25'h0;
			count_reg <= 10'h0;
		end
		else
		begin
			if (wr_en && waddr_reg == OFS_ADDR)
				addr_reg <= 25'(merge({7'h0, addr_reg}, wdata_reg, wstrb_reg));
			if (wr_en && waddr_reg == OFS_DEST)
				dest_reg <= 25'(merge({7'h0, dest_reg}, wdata_reg, wstrb_reg));
			if (state_reg == S_DONE && op_reg == OP_PROGRAM)
				count_reg <= 10'h0;
			else if (wr_en && waddr_reg == OFS_DATA && wstrb_reg[0]
				&& count_reg < 10'(PAGE_BYTES) && state_reg == S_IDLE)
			begin
				buf_mem[count_reg] <= wdata_reg[7:0];
				count_reg <= count_reg + 10'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// guards that keep the flash usage legal
	assign same_page = last_page_reg == addr_reg[24:9];
	always_comb
	begin
		refuse = (state_reg != S_IDLE);
		case (op_t'(wdata_reg[CTRL_OP_LSB +: 3]))
			OP_PROGRAM:
				refuse = refuse || count_reg == 10'h0
					|| (copied_vld_reg && copied_page_reg == addr_reg[24:9])
					|| (same_page && (wdata_reg[CTRL_SPARE_BIT]
						? spare_cnt_reg >= MAX_SPARE_PARTIAL
						: main_cnt_reg >= MAX_MAIN_PARTIAL));
			OP_COPYBACK: refuse = refuse || addr_reg[14] != dest_reg[14];
			OP_ERASE, OP_STATUS, OP_READ_ID, OP_RESET: refuse = refuse;
			default: refuse = 1'b1;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			last_page_reg <= 16'h0;
			main_cnt_reg <= 2'h0;
			spare_cnt_reg <= 2'h0;
			copied_page_reg <= 16'h0;
			copied_vld_reg <= 1'b0;
		end
		else if (start && !refuse)
		begin
			case (op_t'(wdata_reg[CTRL_OP_LSB +: 3]))
				OP_PROGRAM:
				begin
					last_page_reg <= addr_reg[24:9];
					main_cnt_reg <= (same_page ? main_cnt_reg : 2'h0)
						+ {1'b0, !wdata_reg[CTRL_SPARE_BIT]};
					spare_cnt_reg <= (same_page ? spare_cnt_reg : 2'h0)
						+ {1'b0, wdata_reg[CTRL_SPARE_BIT]};
				end
				OP_COPYBACK:
				begin
					copied_page_reg <= dest_reg[24:9];
					copied_vld_reg <= 1'b1;
				end
				OP_ERASE:
				begin
					if (last_page_reg[15:5] == addr_reg[24:14])
					begin
						main_cnt_reg <= 2'h0;
						spare_cnt_reg <= 2'h0;
					end
					if (copied_page_reg[15:5] == addr_reg[24:14])
						copied_vld_reg <= 1'b0;
				end
				default: copied_vld_reg <= copied_vld_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// operation sequencer
	always_comb
	begin
		case (op_reg)
			OP_ERASE: nadr = 2'h2;
			OP_READ_ID: nadr = 2'h1;
			OP_RESET, OP_STATUS: nadr = 2'h0;
			default: nadr = 2'h3;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= S_PWR;
			op_reg <= OP_STATUS;
			spare_reg <= 1'b0;
			phase_reg <= 1'b0;
			cmd_reg <= CMD_STATUS;
			acnt_reg <= 2'h0;
			dcnt_reg <= 10'h0;
			rcnt_reg <= 1'b0;
			wcnt_reg <= 4'h0;
			pwr_cnt_reg <= 11'h0;
			wp_n <= 1'b0;
			refused_reg <= 1'b0;
			status_reg <= FLASH_STATUS_RESET;
			maker_reg <= 8'h00;
			device_reg <= 8'h00;
		end
		else
		begin
			if (start && refuse)
				refused_reg <= 1'b1;
			else if (clr_refused)
				refused_reg <= 1'b0;
			case (state_reg)
				S_PWR:
				begin
					pwr_cnt_reg <= pwr_cnt_reg + 11'h1;
					if (pwr_cnt_reg == 11'(POWERUP_CYC - 1))
					begin
						wp_n <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				S_IDLE:
					if (start && !refuse)
					begin
						op_reg <= op_t'(wdata_reg[CTRL_OP_LSB +: 3]);
						spare_reg <= wdata_reg[CTRL_SPARE_BIT];
						phase_reg <= 1'b0;
						acnt_reg <= 2'h0;
						dcnt_reg <= 10'h0;
						rcnt_reg <= 1'b0;
						case (op_t'(wdata_reg[CTRL_OP_LSB +: 3]))
							OP_PROGRAM: state_reg <= S_PTR;
							OP_STATUS: state_reg <= S_STC;
							OP_COPYBACK: state_reg <= S_CMD;
							OP_ERASE: state_reg <= S_CMD;
							OP_READ_ID: state_reg <= S_CMD;
							default: state_reg <= S_CMD;
						endcase
						case (op_t'(wdata_reg[CTRL_OP_LSB +: 3]))
							OP_PROGRAM: cmd_reg <= CMD_DATA_IN;
							OP_COPYBACK: cmd_reg <= CMD_MAIN_PTR;
							OP_ERASE: cmd_reg <= CMD_ERASE_SETUP;
							OP_READ_ID: cmd_reg <= CMD_READ_ID;
							default: cmd_reg <= CMD_RESET;
						endcase
					end
				S_PTR:
					if (cyc.done)
						state_reg <= S_CMD;
				S_CMD:
					if (cyc.done)
						state_reg <= (nadr == 2'h0) ? S_BUSY : S_ADR;
				S_ADR:
					if (cyc.done && acnt_reg == nadr - 2'h1)
					begin
						case (op_reg)
							OP_PROGRAM: state_reg <= S_DIN;
							OP_ERASE: state_reg <= S_CFM;
							OP_READ_ID: state_reg <= S_RD;
							default: state_reg <= S_BUSY;
						endcase
						cmd_reg <= (op_reg == OP_ERASE) ? CMD_ERASE_CFM : CMD_PROG_CFM;
					end
					else if (cyc.done)
						acnt_reg <= acnt_reg + 2'h1;
				S_DIN:
					if (cyc.done)
					begin
						dcnt_reg <= dcnt_reg + 10'h1;
						if (dcnt_reg == count_reg - 10'h1)
							state_reg <= S_CFM;
					end
				S_CFM:
					if (cyc.done)
						state_reg <= S_BUSY;
				S_BUSY:
					if (wcnt_reg != 4'(WB_CYC))
						wcnt_reg <= wcnt_reg + 4'h1;
					else if (rb_in)
					begin
						wcnt_reg <= 4'h0;
						acnt_reg <= 2'h0;
						if (op_reg == OP_COPYBACK && !phase_reg)
						begin
							phase_reg <= 1'b1;
							cmd_reg <= CMD_COPY_PROG;
							state_reg <= S_CMD;
						end
						else if (op_reg == OP_RESET)
						begin
							status_reg <= FLASH_STATUS_RESET;
							state_reg <= S_DONE;
						end
						else
							state_reg <= S_STC;
					end
				S_STC:
					if (cyc.done)
						state_reg <= S_RD;
				S_RD:
					if (cyc.done)
					begin
						rcnt_reg <= 1'b1;
						if (op_reg != OP_READ_ID)
							status_reg <= cyc.rbyte;
						else if (!rcnt_reg)
							maker_reg <= cyc.rbyte;
						else
							device_reg <= cyc.rbyte;
						if (op_reg != OP_READ_ID || rcnt_reg)
							state_reg <= S_DONE;
					end
				S_DONE: state_reg <= S_IDLE;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// cycle requests to the pin sequencer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cyc.req <= 1'b0;
			issued_reg <= 1'b0;
		end
		else
		begin
			cyc.req <= !issued_reg && !cyc.req && (state_reg inside
				{S_PTR, S_CMD, S_ADR, S_DIN, S_CFM, S_STC, S_RD});
			if (cyc.req)
				issued_reg <= 1'b1;
			else if (cyc.done)
				issued_reg <= 1'b0;
		end
	end

	assign cyc.sel = !(state_reg inside {S_IDLE, S_PWR, S_DONE});
	always_comb
	begin
		cyc.kind = CYC_CMD;
		cyc.wbyte = cmd_reg;
		case (state_reg)
			S_PTR: cyc.wbyte = spare_reg ? CMD_SPARE_PTR : CMD_MAIN_PTR;
			S_ADR:
			begin
				cyc.kind = CYC_ADDR;
				cyc.wbyte = addr_byte(phase_reg ? dest_reg : addr_reg, acnt_reg, op_reg);
			end
			S_DIN:
			begin
				cyc.kind = CYC_DIN;
				cyc.wbyte = buf_mem[dcnt_reg];
			end
			S_STC: cyc.wbyte = CMD_STATUS;
			S_RD: cyc.kind = CYC_DOUT;
			default: cyc.kind = CYC_CMD;
		endcase
	end

	nand_pin_seq #(.IO_W(IO_W)) u_pins (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.cyc           (cyc),
		.ce_n          (ce_n),
		.cle           (cle),
		.ale           (ale),
		.we_n          (we_n),
		.read_strobe_n (read_strobe_n),
		.io_out        (io_out),
		.io_oe         (io_oe),
		.io_in         (io_in)
	);

	////////////////////////////////////////////////////////////////
	property p_empty_program;
		@(posedge aclk) disable iff (!aresetn)
		start && state_reg == S_IDLE && wdata_reg[2:0] == 3'h0 && count_reg == 10'h0
			|=> refused_reg && state_reg == S_IDLE;
	endproperty
	a_empty_program: assert property (p_empty_program) else $error("empty program ran");

	property p_plane;
		@(posedge aclk) disable iff (!aresetn)
		start && wdata_reg[2:0] == 3'h1 && addr_reg[14] != dest_reg[14]
			|=> refused_reg && state_reg != S_CMD;
	endproperty
	a_plane: assert property (p_plane) else $error("cross plane copy started");

	property p_busy_quiet;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == S_BUSY |-> !cyc.req;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("cycle issued while busy");

	property p_rb_wait;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == S_BUSY && !rb_in |=> state_reg == S_BUSY;
	endproperty
	a_rb_wait: assert property (p_rb_wait) else $error("left busy with rb low");

	property p_powerup;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == S_PWR |-> !wp_n && ce_n;
	endproperty
	a_powerup: assert property (p_powerup) else $error("flash touched during power-up");

	property p_upper_zero;
		@(posedge aclk) disable iff (!aresetn)
		(cle || ale) |-> (io_out >> 8) == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper io lines not zero");

	property p_id_two_reads;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == S_RD && op_reg == OP_READ_ID && cyc.done && !rcnt_reg
			|=> state_reg == S_RD;
	endproperty
	a_id_two_reads: assert property (p_id_two_reads) else $error("id read ended early");

	property p_partial;
		@(posedge aclk) disable iff (!aresetn)
		main_cnt_reg <= MAX_MAIN_PARTIAL && spare_cnt_reg <= MAX_SPARE_PARTIAL;
	endproperty
	a_partial: assert property (p_partial) else $error("partial program count exceeded");
endmodule : nand_host_ctrl

/* core/nand_host_pkg.sv */
// Purpose: constants for the nand flash host controller
// Assumes: 125 MHz aclk, axi4-lite register port, 8-bit or 16-bit flash bus
// Notes: the flash status byte layout is mirrored here for decoding
package nand_host_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_DEST = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_IDENT = 8'h14;
	// control and status fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_SPARE_BIT = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FAIL_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;
	localparam int STAT_BYTE_LSB = 8;
	localparam int STAT_COUNT_LSB = 16;
	localparam logic [7:0] FLASH_STATUS_RESET = 8'hC0;
	localparam int FS_FAIL_BIT = 0;
	localparam int FS_READY_BIT = 6;
	localparam int FS_UNPROT_BIT = 7;
	// flash commands
	localparam logic [7:0] CMD_MAIN_PTR = 8'h00;
	localparam logic [7:0] CMD_SPARE_PTR = 8'h50;
	localparam logic [7:0] CMD_DATA_IN = 8'h80;
	localparam logic [7:0] CMD_PROG_CFM = 8'h10;
	localparam logic [7:0] CMD_COPY_PROG = 8'h8A;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_CFM = 8'hD0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] ID_ADDR = 8'h00;
	// page geometry and partial program limits
	localparam int PAGE_BYTES = 528;
	localparam logic [1:0] MAX_MAIN_PARTIAL = 2'h2;
	localparam logic [1:0] MAX_SPARE_PARTIAL = 2'h3;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int T_POWERUP_US = 10;
	localparam int POWERUP_CYC = T_POWERUP_US * CLK_MHZ;
	localparam int T_STROBE_LOW_NS = 40;
	localparam int T_STROBE_HIGH_NS = 24;
	localparam int T_WB_NS = 100;
	localparam int STROBE_LOW_CYC = (T_STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_HIGH_CYC = (T_STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int WB_CYC = (T_WB_NS * CLK_MHZ + 999) / 1000;
	// operations and bus cycle kinds
	typedef enum logic [2:0]
	{
		OP_PROGRAM = 3'h0, OP_COPYBACK = 3'h1, OP_ERASE = 3'h2,
		OP_STATUS = 3'h3, OP_READ_ID = 3'h4, OP_RESET = 3'h5
	} op_t;
	typedef enum logic [1:0]
	{
		CYC_CMD = 2'h0, CYC_ADDR = 2'h1, CYC_DIN = 2'h2, CYC_DOUT = 2'h3
	} cyc_kind_t;
endpackage : nand_host_pkg

/* core/nand_cycle_if.sv */
// Purpose: one flash bus cycle request between controller and pin sequencer
// Assumes: req is a one-cycle pulse, done a one-cycle pulse
// Notes: sel keeps chip enable asserted across a whole operation
`timescale 1ns/100ps
interface nand_cycle_if;
	import nand_host_pkg::*;
	logic       req;
	logic       sel;
	cyc_kind_t  kind;
	logic [7:0] wbyte;
	logic       done;
	logic [7:0] rbyte;
	modport ctrl (output req, sel, kind, wbyte, input done, rbyte);
	modport seq (input req, sel, kind, wbyte, output done, rbyte);
endinterface : nand_cycle_if

/* core/nand_pin_seq.sv */
// Purpose: drives one command, address or data cycle on the flash pins
// Assumes: pins are synchronous to aclk
// Notes: all pin outputs are flops
`timescale 1ns/100ps
module nand_pin_seq #(
	parameter int IO_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	nand_cycle_if.seq              cyc,
	output logic                   ce_n,
	output logic                   cle,
	output logic                   ale,
	output logic                   we_n,
	output logic                   read_strobe_n,
	output logic [IO_W-1:0]        io_out,
	output logic [IO_W-1:0]        io_oe,
	input  wire logic [IO_W-1:0]   io_in
);
	import nand_host_pkg::*;
	logic       act_reg;
	logic [3:0] cnt_reg;
	logic       rd_reg;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			act_reg <= 1'b0;
			cnt_reg <= 4'h0;
			rd_reg <= 1'b0;
			cle <= 1'b0;
			ale <= 1'b0;
			we_n <= 1'b1;
			read_strobe_n <= 1'b1;
			io_out <= '0;
			io_oe <= '0;
			cyc.done <= 1'b0;
			cyc.rbyte <= 8'h00;
			ce_n <= 1'b1;
		end
		else
		begin
			ce_n <= ~cyc.sel;
			cyc.done <= 1'b0;
			if (!act_reg && cyc.req)
			begin
				act_reg <= 1'b1;
				cnt_reg <= 4'(STROBE_LOW_CYC - 1);
				rd_reg <= (cyc.kind == CYC_DOUT);
				cle <= (cyc.kind == CYC_CMD);
				ale <= (cyc.kind == CYC_ADDR);
				io_out <= IO_W'(cyc.wbyte);
				io_oe <= (cyc.kind == CYC_DOUT) ? '0 : '1;
				we_n <= (cyc.kind == CYC_DOUT);
				read_strobe_n <= (cyc.kind != CYC_DOUT);
			end
			else if (act_reg && cnt_reg != 4'h0)
				cnt_reg <= cnt_reg - 4'h1;
			else if (act_reg && (!we_n || !read_strobe_n))
			begin
				if (rd_reg)
					cyc.rbyte <= io_in[7:0];
				we_n <= 1'b1;
				read_strobe_n <= 1'b1;
				cnt_reg <= 4'(STROBE_HIGH_CYC - 1);
			end
			else if (act_reg)
			begin
				act_reg <= 1'b0;
				cle <= 1'b0;
				ale <= 1'b0;
				io_oe <= '0;
				cyc.done <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	property p_latch_excl;
		@(posedge aclk) disable iff (!aresetn)
		!(cle && ale);
	endproperty
	a_latch_excl: assert property (p_latch_excl) else $error("cle and ale both high");

	property p_we_pulse;
		@(posedge aclk) disable iff (!aresetn)
		$fell(we_n) |-> (!we_n)[*5] ##1 we_n;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
endmodule : nand_pin_seq

/* verif/nand_flash_model.sv */
// Purpose: behavioural nand flash device facing the host controller
// Assumes: pins are flops on aclk, so strobe edges are seen on aclk
// Notes: busy lasts 40 cycles; released io lines show the inverse byte
`timescale 1ns/100ps
module nand_flash_model #(
	parameter logic [7:0] MAKER  = 8'h3C,
	parameter logic [7:0] DEVICE = 8'h5A
) (
	input  wire logic        aclk,
	input  wire logic        ce_n,
	input  wire logic        cle,
	input  wire logic        ale,
	input  wire logic        we_n,
	input  wire logic        read_strobe_n,
	input  wire logic        wp_n,
	input  wire logic [7:0]  io_out,
	input  wire logic        fail_in,
	output logic [7:0]       io_in,
	output logic             rb_low,
	output logic [7:0]       last_cmd = 8'h00,
	output logic [9:0]       n_data = 10'h000,
	output logic [10:0]      blk = 11'h000,
	output logic [7:0]       ptr = 8'h00
);
	logic [7:0] cmd = 8'h00;
	logic [7:0] held = 8'h00;
	logic [7:0] a1 = 8'h00;
	logic [7:0] val;
	logic [1:0] n_addr = 2'h0;
	logic [5:0] busy = 6'h00;
	logic       n_id = 1'b0;
	logic       fail = 1'b0;
	logic       we_d = 1'b1;
	logic       rs_d = 1'b1;
	logic       drive;
	////////////////////////////////////////////////////////////////
	assign rb_low = busy != 6'h00;
	assign drive = !ce_n && !read_strobe_n;
	assign val = cmd == 8'h90 ? (n_id ? DEVICE : MAKER) : {wp_n, ~rb_low, 5'h00, fail};
	assign io_in = drive ? val : ~held;
	always @(posedge aclk)
	begin
		we_d <= we_n;
		rs_d <= read_strobe_n;
		if (drive) held <= val;
		if (busy != 6'h00) busy <= busy - 6'h01;
		if (busy == 6'h01) fail <= fail_in;
		if (read_strobe_n && !rs_d) n_id <= 1'b1;
		if (!ce_n && we_n && !we_d)
		begin
			if (cle && (busy == 6'h00 || io_out == 8'h70 || (io_out == 8'hFF && cmd != 8'hFF)))
			begin
				cmd <= io_out;
				if (io_out != 8'h70) last_cmd <= io_out;
				n_addr <= 2'h0;
				n_id <= 1'b0;
				if (io_out == 8'h80) n_data <= 10'h000;
				if ((io_out == 8'h10 && n_data != 10'h000) || io_out == 8'hD0 || io_out == 8'hFF) busy <= 6'd40;
				if (io_out == 8'hFF) fail <= 1'b0;
				if (io_out == 8'h00 || io_out == 8'h50) ptr <= io_out;
			end
			else if (ale)
			begin
				a1 <= io_out;
				n_addr <= n_addr + 2'h1;
				if (cmd == 8'h60 && n_addr == 2'h1) blk <= {io_out, a1[7:5]};
				if ((cmd == 8'h00 || cmd == 8'h8A) && n_addr == 2'h2) busy <= 6'd40;
			end
			else if (!cle && cmd == 8'h80 && n_data != 10'd528) n_data <= n_data + 10'h001;
		end
	end
endmodule : nand_flash_model

/* verif/nand_host_ctrl_bench.sv */
// Purpose: register level bench for the nand host controller
// Assumes: flash model answers every operation within 40 cycles
// Notes: fail_in makes the next operation that goes busy report failure
`timescale 1ns/100ps
module nand_host_ctrl_bench;
	import nand_host_pkg::*;
	localparam logic [7:0]  MK = 8'h3C; // arbitrary value
	localparam logic [7:0]  DV = 8'h5A; // arbitrary value
	localparam logic [24:0] PG = 25'h0004200;
	localparam logic [24:0] DS = 25'h0104200;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        fail_in = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, ce_n, cle, ale, we_n, rs_n, wp_n, rb_low;
	logic [1:0]  bresp, rresp, rr;
	logic [31:0] rdata, rv;
	logic [7:0]  io_out, io_in, last_cmd, ptr;
	logic [9:0]  n_data;
	logic [10:0] blk;
	int          fail_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////
	always #4 aclk = ~aclk;
	nand_host_ctrl #(.IO_W(8)) u_nand_host_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(rs_n),
		.wp_n(wp_n), .io_out(io_out), .io_oe(), .io_in(io_in), .rb_in(~rb_low));
	nand_flash_model #(.MAKER(MK), .DEVICE(DV)) u_nand_flash_model (.aclk(aclk), .ce_n(ce_n),
		.cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(rs_n), .wp_n(wp_n), .io_out(io_out),
		.fail_in(fail_in), .io_in(io_in), .rb_low(rb_low), .last_cmd(last_cmd),
		.n_data(n_data), .blk(blk), .ptr(ptr));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic op(input op_t o, input logic sp = 1'b0);
		wr(OFS_CTRL, {28'h0, sp, o});
		do rd(OFS_STAT);
		while (rv[0] !== 1'b0);
	endtask : op
	task complete_run;
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fail_count++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_STAT);
		chk(rv & 32'hFFFF, 32'hC001);
		wr(OFS_CTRL, {29'h0, OP_STATUS});
		rd(OFS_STAT);
		chk(rv & 32'h4, 32'h4);
		wr(OFS_STAT, 32'h4);
		rd(8'h18);
		chk({30'h0, rr}, 32'h2);
		do rd(OFS_STAT);
		while (rv[0] !== 1'b0);
		op(OP_READ_ID);
		rd(OFS_IDENT);
		chk(rv & 32'hFFFF, {16'h0, DV, MK});
		wr(OFS_ADDR, {7'h0, PG});
		repeat (3) wr(OFS_DATA, 32'hA5);
		op(OP_PROGRAM);
		chk(rv & 32'hFFFF, 32'hC000);
		chk({22'h0, n_data}, 32'h3);
		op(OP_PROGRAM);
		chk(rv & 32'h4, 32'h4);
		wr(OFS_STAT, 32'h4);
		fail_in <= 1'b1;
		wr(OFS_DATA, 32'h5A);
		op(OP_PROGRAM);
		chk(rv & 32'hFFFF, 32'hC102);
		fail_in <= 1'b0;
		wr(OFS_DATA, 32'h3C);
		op(OP_PROGRAM);
		chk(rv & 32'h4, 32'h4);
		wr(OFS_STAT, 32'h4);
		op(OP_ERASE);
		chk({21'h0, blk}, {21'h0, PG[24:14]});
		chk({24'h0, last_cmd}, 32'hD0);
		chk(rv & 32'hFFFF, 32'hC000);
		wr(OFS_DATA, 32'h5A);
		op(OP_PROGRAM, 1'b1);
		chk({24'h0, ptr}, 32'h50);
		wr(OFS_DEST, {7'h0, DS ^ 25'h4000});
		op(OP_COPYBACK);
		chk(rv & 32'h4, 32'h4);
		wr(OFS_STAT, 32'h4);
		wr(OFS_DEST, {7'h0, DS});
		op(OP_COPYBACK);
		chk({24'h0, last_cmd}, 32'h8A);
		wr(OFS_ADDR, {7'h0, DS});
		wr(OFS_DATA, 32'hA5);
		op(OP_PROGRAM);
		chk(rv & 32'h4, 32'h4);
		wr(OFS_STAT, 32'h4);
		op(OP_RESET);
		chk({24'h0, last_cmd}, 32'hFF);
		chk(rv & 32'hFFFF, 32'hC000);
		op(OP_STATUS);
		chk(rv & 32'hFF00, 32'hC000);
		complete_run();
	end
endmodule : nand_host_ctrl_bench
